/* sinc3_seq_pkg.sv */
// shared constants, tables and types of the conversion timing sequencer
package sinc3_seq_pkg;

    // ----------------------------------------------------------------
    // clock and timebase
    // ----------------------------------------------------------------
    localparam int          CLK_HZ     = 25_000_000;
    localparam int          FCLK_REF_HZ = 4_096_000;
    localparam int          MOD_DIV    = 16;
    localparam int          DIV_W      = 4;
    localparam int          CNT_W      = 19;
    localparam int          NUM_RATES  = 14;
    localparam logic [1:0]  SETTLE_DISCARDS = 2'h2;

    typedef logic [CNT_W-1:0] cnt_t;

    // ----------------------------------------------------------------
    // register map (byte addresses) and fields
    // ----------------------------------------------------------------
    localparam logic [7:0]  GAIN_OFS   = 8'h00;
    localparam logic [7:0]  DRATE_OFS  = 8'h04;
    localparam logic [7:0]  CTRL_OFS   = 8'h08;
    localparam logic [7:0]  STAT_OFS   = 8'h0c;
    localparam logic [7:0]  COUNT_OFS  = 8'h10;

    localparam int          DELAY_LSB  = 0;
    localparam int          DELAY_W    = 3;
    localparam int          RATE_LSB   = 0;
    localparam int          RATE_W     = 4;
    localparam int          FILTER_BIT = 4;
    localparam int          SINGLE_BIT = 5;
    localparam int          DRATE_W    = 6;
    localparam int          START_BIT  = 0;
    localparam int          STOP_BIT   = 1;

    localparam logic [DELAY_W-1:0] GAIN_RST  = 3'h0;
    localparam logic [DRATE_W-1:0] DRATE_RST = 6'h04;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_DELAY  = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_FIRST  = 5'b01000,
        ST_RUN    = 5'b10000
    } seq_state_t;

    // ----------------------------------------------------------------
    // timing tables in modulator periods, index = rate code, or delay code for DELAY_TAB
    // ----------------------------------------------------------------
    localparam cnt_t FIRST_SINC [NUM_RATES] = '{
        19'd307265, 19'd153665, 19'd76865, 19'd46145, 19'd38465,
        19'd15425,  19'd12857,  19'd7745,  19'd3905,  19'd1985,
        19'd1025,   19'd808,    19'd424,   19'd232};
    localparam cnt_t FIRST_LL [NUM_RATES] = '{
        19'd104065, 19'd52865, 19'd27265, 19'd15425, 19'd14465,
        19'd5160,   19'd4329,  19'd2600,  19'd1320,  19'd680,
        19'd360,    19'd296,   19'd168,   19'd104};
    localparam cnt_t SUB_PERIOD [NUM_RATES] = '{
        19'd102400, 19'd51200, 19'd25600, 19'd15360, 19'd12800,
        19'd5120,   19'd4264,  19'd2560,  19'd1280,  19'd640,
        19'd320,    19'd256,   19'd128,   19'd64};
    localparam cnt_t DELAY_TAB [8] = '{
        19'd14, 19'd28, 19'd42, 19'd56,
        19'd70, 19'd84, 19'd98, 19'd112};

endpackage

/* pin_edge_sync.sv */
// three-stage pin synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
module pin_edge_sync (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    // pin and result
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise
);
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic next_level;
    logic rise;
    logic next_rise;

    // a change counts only once stages two and three agree
    always_comb begin
        next_level = level;
        if (s2 == s3) begin
            next_level = s3;
        end
        next_rise = next_level & ~level;
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            s1    <= i_pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
            rise  <= next_rise;
        end
    end

    assign o_level = level;
    assign o_rise  = rise;
endmodule

/* mod_tick_div.sv */
// divider giving one enable pulse per modulator period
`timescale 1ns/1ps
module mod_tick_div
    import sinc3_seq_pkg::*;
(
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_arst_n,
    // control and tick
    input  wire logic i_clear,
    output logic      o_tick
);
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] next_div;
    logic             last;

    assign last = (div == DIV_W'(MOD_DIV - 1));

    // clearing realigns the period so the first tick is a full period away
    always_comb begin
        next_div = last ? '0 : div + 1'b1;
        if (i_clear) begin
            next_div = '0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    assign o_tick = last & ~i_clear;
endmodule

/* sinc3_conversion_timing_sequencer.sv */
// conversion timing sequencer with apb register slave
`timescale 1ns/1ps
module sinc3_conversion_timing_sequencer
    import sinc3_seq_pkg::*;
#(
    parameter sinc3_seq_pkg::cnt_t SIM_COUNT_CAP = 19'h7ffff
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // start sources
    input  wire logic        i_start_pin,
    input  wire logic        i_start_cmd,
    // conversion events and status
    output logic             o_data_ready,
    output logic             o_discard,
    output logic             o_busy,
    output logic             o_filter_sinc
);
    import sinc3_seq_pkg::*;

    // ----------------------------------------------------------------
    // table lookups
    // ----------------------------------------------------------------
    // codes above the table use the fastest rate
    function automatic logic [3:0] rate_idx(input logic [RATE_W-1:0] code);
        rate_idx = (code > 4'(NUM_RATES - 1)) ? 4'(NUM_RATES - 1) : code;
    endfunction

    // long counts saturate at the cap so a simulation can shorten them
    function automatic cnt_t capped(input cnt_t n);
        cnt_t v;
        v = (n > SIM_COUNT_CAP) ? SIM_COUNT_CAP : n;
        capped = (v == '0) ? cnt_t'(1) : v;
    endfunction

    function automatic cnt_t sub_len(input logic [RATE_W-1:0] code);
        sub_len = capped(SUB_PERIOD[rate_idx(code)]);
    endfunction

    // sinc3 first result minus the two suppressed periods already spent
    function automatic cnt_t first_len(input logic [RATE_W-1:0] code,
                                       input logic sinc);
        cnt_t t;
        cnt_t s;
        t = sinc ? FIRST_SINC[rate_idx(code)] : FIRST_LL[rate_idx(code)];
        s = SUB_PERIOD[rate_idx(code)];
        if (sinc) begin
            t = t - {s[CNT_W-2:0], 1'b0};
        end
        first_len = capped(t);
    endfunction

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic bus_wr;
    logic bus_setup;
    logic addr_ok;

    // unmapped writes match no decode below, so they change nothing
    assign bus_wr    = i_psel & i_penable & i_pwrite;
    assign bus_setup = i_psel & ~i_penable;
    // five words are mapped; any other address answers with an error
    assign addr_ok   = (i_paddr == GAIN_OFS)  | (i_paddr == DRATE_OFS) |
                       (i_paddr == CTRL_OFS)  | (i_paddr == STAT_OFS)  |
                       (i_paddr == COUNT_OFS);

    // zero wait states; read data was captured in the setup cycle
    assign o_pready  = i_psel & i_penable;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;

    // ----------------------------------------------------------------
    // start sources
    // ----------------------------------------------------------------
    logic pin_rise;
    logic tick;
    logic start_req;
    logic stop_req;

    // a pin edge reaches start_req four clocks after the pin rises
    pin_edge_sync u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_pin     (i_start_pin),
        .o_level   (),
        .o_rise    (pin_rise)
    );

    assign start_req = pin_rise | i_start_cmd |
                       (bus_wr & (i_paddr == CTRL_OFS) & i_pwdata[START_BIT]);
    // control bits are strobes; the control word itself is not stored
    assign stop_req  = bus_wr & (i_paddr == CTRL_OFS) & i_pwdata[STOP_BIT];

    // start clears the divider so the first period is a whole one
    // sixteen clocks per period
    mod_tick_div u_div (
        .i_ref_clk (i_ref_clk),
        .i_arst_n  (i_arst_n),
        .i_clear   (start_req),
        .o_tick    (tick)
    );

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    logic [DELAY_W-1:0] gain_reg;
    logic [DELAY_W-1:0] next_gain_reg;
    logic [DRATE_W-1:0] drate_reg;
    logic [DRATE_W-1:0] next_drate_reg;
    logic [31:0]        rdata;
    logic [31:0]        next_rdata;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    seq_state_t         state;
    seq_state_t         next_state;
    cnt_t               cnt;
    cnt_t               next_cnt;
    logic [1:0]         disc_cnt;
    logic [1:0]         next_disc_cnt;
    // run copies freeze the settings taken at start
    logic [RATE_W-1:0]  run_rate;
    logic [RATE_W-1:0]  next_run_rate;
    logic               run_sinc;
    logic               next_run_sinc;
    logic               run_single;
    logic               next_run_single;
    logic               ready;
    logic               next_ready;
    logic               discard;
    logic               next_discard;
    logic [15:0]        result_cnt;
    logic [15:0]        next_result_cnt;
    logic               done;

    // a count of one on a tick closes the current interval
    assign done = tick & (cnt == cnt_t'(1));

    // ----------------------------------------------------------------
    // configuration write path
    // ----------------------------------------------------------------
    always_comb begin
        next_gain_reg  = gain_reg;
        next_drate_reg = drate_reg;
        if (bus_wr & (i_paddr == GAIN_OFS)) begin
            next_gain_reg = i_pwdata[DELAY_LSB +: DELAY_W];
        end
        if (bus_wr & (i_paddr == DRATE_OFS)) begin
            next_drate_reg = i_pwdata[DRATE_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = rdata;
        if (bus_setup & ~i_pwrite) begin
            case (i_paddr)
                GAIN_OFS:  next_rdata = {29'h0, gain_reg};
                DRATE_OFS: next_rdata = {26'h0, drate_reg};
                // only the top count bits, enough to watch progress
                STAT_OFS:  next_rdata = {20'h0, cnt[CNT_W-1:CNT_W-5],
                                         disc_cnt, state};
                COUNT_OFS: next_rdata = {16'h0, result_cnt};
                default:   next_rdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state      = state;
        next_cnt        = cnt;
        next_disc_cnt   = disc_cnt;
        next_run_rate   = run_rate;
        next_run_sinc   = run_sinc;
        next_run_single = run_single;
        // event pulses last a single clock
        next_ready      = 1'b0;
        next_discard    = 1'b0;
        next_result_cnt = result_cnt;
        if (start_req) begin
            // settings are frozen for the whole run
            next_run_rate   = drate_reg[RATE_LSB +: RATE_W];
            next_run_sinc   = ~drate_reg[FILTER_BIT];
            next_run_single = drate_reg[SINGLE_BIT];
            // a sinc3 restart discards two unsettled results again
            next_disc_cnt   = '0;
            // delay ahead of the first conversion
            next_cnt        = capped(DELAY_TAB[gain_reg]);
            next_state      = ST_DELAY;
        // a start in the same cycle outranks the stop
        end else if (stop_req) begin
            next_state = ST_IDLE;
            next_cnt   = '0;
        end else if (tick && state != ST_IDLE) begin
            // counts run down one per modulator period
            next_cnt = cnt - 1'b1;
            if (done) begin
                case (state)
                    ST_DELAY: begin
                        if (run_sinc) begin
                            next_cnt   = sub_len(run_rate);
                            next_state = ST_SETTLE;
                        end else begin
                            next_cnt   = first_len(run_rate, 1'b0);
                            next_state = ST_FIRST;
                        end
                    end
                    ST_SETTLE: begin
                        next_discard  = 1'b1;
                        next_disc_cnt = disc_cnt + 1'b1;
                        if (next_disc_cnt == SETTLE_DISCARDS) begin
                            next_cnt   = first_len(run_rate, 1'b1);
                            next_state = ST_FIRST;
                        end else begin
                            next_cnt = sub_len(run_rate);
                        end
                    end
                    ST_FIRST: begin
                        next_ready      = 1'b1;
                        next_result_cnt = result_cnt + 1'b1;
                        if (run_single) begin
                            next_state = ST_IDLE;
                            next_cnt   = '0;
                        end else begin
                            next_cnt   = sub_len(run_rate);
                            next_state = ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        next_ready      = 1'b1;
                        next_result_cnt = result_cnt + 1'b1;
                        next_cnt        = sub_len(run_rate);
                    end
                    default: begin
                        next_state = ST_IDLE;
                        next_cnt   = '0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // register stages
    // ----------------------------------------------------------------
    // configuration group
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gain_reg  <= GAIN_RST;
            drate_reg <= DRATE_RST;
        end else begin
            gain_reg  <= next_gain_reg;
            drate_reg <= next_drate_reg;
        end
    end

    // read data group
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // the interval count cnt is in modulator periods of the input clock
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state      <= ST_IDLE;
            cnt        <= '0;
            disc_cnt   <= 2'h0;
            run_rate   <= 4'h0;
            run_sinc   <= 1'b1;
            run_single <= 1'b0;
            ready      <= 1'b0;
            discard    <= 1'b0;
            result_cnt <= 16'h0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            disc_cnt   <= next_disc_cnt;
            run_rate   <= next_run_rate;
            run_sinc   <= next_run_sinc;
            run_single <= next_run_single;
            ready      <= next_ready;
            discard    <= next_discard;
            result_cnt <= next_result_cnt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_prdata      = rdata;
    assign o_data_ready  = ready;
    assign o_discard     = discard;
    // busy follows the state register, not the start strobes
    assign o_busy        = (state != ST_IDLE);
    // the flag shows the inverse of the programmed bit; a running conversion keeps its copy
    assign o_filter_sinc = ~drate_reg[FILTER_BIT];
endmodule

/* seq_monitor.sv */
// concurrent checks on the conversion sequencer ports
`timescale 1ns/1ps
module seq_monitor
    import sinc3_seq_pkg::*;
#(
    parameter cnt_t SIM_COUNT_CAP = 19'h7ffff
) (
    input wire logic        i_ref_clk,
    input wire logic        i_arst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_start_pin,
    input wire logic        i_start_cmd,
    input wire logic        o_data_ready,
    input wire logic        o_discard,
    input wire logic        o_busy,
    input wire logic        o_filter_sinc
);
    // --------------------------------------------------------------
    // elapsed-cycle helpers
    // --------------------------------------------------------------
    // shortest legal gaps: 16 * (14 + 104) and 16 * (14 + 64) clocks,
    // plus one because the counter restarts at one on the command edge
    localparam int FIRST_MIN = 1889;
    localparam int DISC_MIN  = 1249;
    localparam int GAP_MIN   = 1024;
    localparam int SAT       = 1000000;
    int   since_cmd;
    int   since_rdy;
    int   next_since_cmd;
    int   next_since_rdy;
    logic stop_wr;

    assign stop_wr = i_psel & i_penable & i_pwrite &
                     (i_paddr == CTRL_OFS) & i_pwdata[STOP_BIT];

    always_comb begin
        next_since_cmd = (since_cmd < SAT) ? since_cmd + 1 : since_cmd;
        next_since_rdy = (since_rdy < SAT) ? since_rdy + 1 : since_rdy;
        if (i_start_cmd) begin
            next_since_cmd = 1;
        end
        if (o_data_ready) begin
            next_since_rdy = 1;
        end
    end

    // saturated start values so nothing fires before the first start
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            since_cmd <= SAT;
            since_rdy <= SAT;
        end else begin
            since_cmd <= next_since_cmd;
            since_rdy <= next_since_rdy;
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    a_filter_select: assert property (
        i_psel && i_penable && i_pwrite && i_paddr == DRATE_OFS |=>
        o_filter_sinc == !$past(i_pwdata[FILTER_BIT]))
        else $error("filter flag does not follow the select bit");
    a_cmd_starts_busy: assert property (
        i_start_cmd && !stop_wr |=> o_busy)
        else $error("start command did not make the sequencer busy");
    a_discard_settle: assert property (
        o_discard |-> since_cmd >= DISC_MIN)
        else $error("suppressed result came too early");
    a_first_min_time: assert property (
        o_data_ready |-> since_cmd >= FIRST_MIN)
        else $error("first result earlier than delay plus conversion");
    a_discard_quiet: assert property (
        o_discard |=> (!o_discard && !o_data_ready) [*8])
        else $error("result pulse right after a suppressed one");
    a_ready_spacing: assert property (
        o_data_ready |-> since_rdy >= GAP_MIN)
        else $error("results closer than one data period");
    a_ready_excl: assert property (
        !(o_data_ready && o_discard))
        else $error("result both output and suppressed");
    a_busy_ends: assert property (
        $fell(o_busy) |-> o_data_ready || $past(o_data_ready) ||
        $past(stop_wr) || $past(stop_wr, 2))
        else $error("busy fell without result or stop");
    a_pready_zero_wait: assert property (
        i_psel && i_penable |-> o_pready)
        else $error("bus access not answered at once");

    c_ready:    cover property (o_data_ready);
    c_discard:  cover property (o_discard);
    c_busy_end: cover property ($fell(o_busy));
endmodule

bind sinc3_conversion_timing_sequencer seq_monitor
    #(.SIM_COUNT_CAP(SIM_COUNT_CAP)) u_mon (.*);

/* host_start_model.sv */
// host side model issuing conversion starts by command or trigger pin
`timescale 1ns/1ps
module host_start_model (
    input  wire logic       i_ref_clk,
    input  wire logic [1:0] i_kind,
    output logic            o_start_cmd,
    output logic            o_start_pin
);
    int hold;

    // pin rests low between triggers, as with a pull-down
    initial begin
        o_start_cmd = 1'b0;
        o_start_pin = 1'b0;
        hold = 0;
    end

    always @(posedge i_ref_clk) begin
        o_start_cmd <= (i_kind == 2'h1);
        hold <= (i_kind == 2'h2) ? 8 : ((hold > 0) ? hold - 1 : 0);
        o_start_pin <= (i_kind == 2'h2) || (hold > 1);
    end
endmodule

/* testbench.sv */
// self-checking bench for the conversion timing sequencer
`timescale 1ns/1ps
module testbench;
    import sinc3_seq_pkg::*;
    typedef struct {
        logic [5:0] drate;
        logic [2:0] gain;
        int rdy;
        int d1;
        int d2;
    } row_t;
    logic        i_ref_clk, i_arst_n, i_psel, i_penable, i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic        o_pready, o_pslverr, i_start_pin, i_start_cmd, err;
    logic        o_data_ready, o_discard, o_busy, o_filter_sinc;
    logic [1:0]  host_kind;
    int          mismatches, n_tests, cycles, t_rdy, t_d1, t_d2, n_d;
    row_t        rows [5];

    sinc3_conversion_timing_sequencer #(.SIM_COUNT_CAP(19'h7ffff)) u_dut (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_start_pin(i_start_pin),
        .i_start_cmd(i_start_cmd), .o_data_ready(o_data_ready),
        .o_discard(o_discard), .o_busy(o_busy),
        .o_filter_sinc(o_filter_sinc));
    host_start_model u_host (.i_ref_clk(i_ref_clk), .i_kind(host_kind),
        .o_start_cmd(i_start_cmd), .o_start_pin(i_start_pin));

    initial i_ref_clk = 1'b0;
    always #20 i_ref_clk = ~i_ref_clk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_ref_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        // only the bench timeout ends a wait for ready
        do begin
            @(posedge i_ref_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // returns at the edge where the design takes a command start
    task automatic go(input logic [1:0] k);
        @(posedge i_ref_clk);
        host_kind <= k;
        @(posedge i_ref_clk);
        host_kind <= 2'h0;
        @(posedge i_ref_clk);
    endtask

    // cycles from the current edge to suppressed and output results
    task automatic measure();
        int k;
        k = 0;
        n_d = 0;
        t_d1 = 0;
        t_d2 = 0;
        t_rdy = 0;
        while (t_rdy == 0 && k < 20000) begin
            @(posedge i_ref_clk);
            #1;
            k++;
            if (o_discard === 1'b1) begin
                n_d++;
                if (n_d == 1) t_d1 = k;
                else t_d2 = k;
            end
            if (o_data_ready === 1'b1) t_rdy = k;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // a hang costs one mismatch; the whole run needs about 41k cycles
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {i_arst_n, i_psel, i_penable, i_pwrite} = 4'h0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        host_kind = 2'h0;
        {mismatches, n_tests, cycles} = '0;
        // expected cycles after the start edge: 16 * (delay + table)
        rows[0] = '{6'h2d, 3'h0, 3936, 1248, 2272};
        rows[1] = '{6'h3d, 3'h0, 1888, 0, 0};
        rows[2] = '{6'h2c, 3'h7, 8576, 3840, 5888};
        rows[3] = '{6'h2d, 3'h3, 4608, 1920, 2944};
        rows[4] = '{6'h3b, 3'h1, 5184, 0, 0};
        repeat (2) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        #1 chk(o_filter_sinc, 32'h1);
        apb(1'b0, DRATE_OFS, 32'h0);
        chk(rd, 32'h04);
        apb(1'b0, GAIN_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h14, 32'hffff_ffff);
        chk(err, 32'h1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, GAIN_OFS, 32'(rows[i].gain));
            apb(1'b1, DRATE_OFS, 32'(rows[i].drate));
            #1 chk(o_filter_sinc, 32'(!rows[i].drate[4]));
            go(2'h1);
            #1 chk(o_busy, 32'h1);
            measure();
            chk(t_rdy, rows[i].rdy);
            chk(t_d1, rows[i].d1);
            chk(t_d2, rows[i].d2);
            @(posedge i_ref_clk);
            #1 chk(o_busy, 32'h0);
        end
        apb(1'b1, GAIN_OFS, 32'h0);
        apb(1'b1, DRATE_OFS, 32'h0d);
        go(2'h1);
        measure();
        chk(t_rdy, 3936);
        measure();
        chk(t_rdy, 1024);
        chk(n_d, 0);
        apb(1'b1, CTRL_OFS, 32'h2);
        @(posedge i_ref_clk);
        #1 chk(o_busy, 32'h0);
        apb(1'b1, DRATE_OFS, 32'h2d);
        go(2'h1);
        repeat (100) @(posedge i_ref_clk);
        go(2'h1);
        measure();
        chk(t_rdy, 3936);
        chk(t_d1, 1248);
        apb(1'b1, CTRL_OFS, 32'h1);
        measure();
        chk(t_rdy, 3936);
        go(2'h2);
        measure();
        chk(32'(t_rdy >= 3939 && t_rdy <= 3941), 32'h1);
        apb(1'b0, COUNT_OFS, 32'h0);
        chk(rd, 32'h0a);
        go(2'h1);
        repeat (20) @(posedge i_ref_clk);
        i_arst_n <= 1'b0;
        #1 chk(o_busy, 32'h0);
        @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        apb(1'b0, DRATE_OFS, 32'h0);
        chk(rd, 32'h04);
        end_of_test();
    end
endmodule
